/* File: core/fcr_consts.svh */
// Purpose: Offsets, reset values and timing figures of the fault configuration register bank
// Assumes: 100 MHz system clock; register indices as seen on the serial bus with bit 7 stripped
// Notes: Definitions only
`ifndef FCR_CONSTS_SVH
`define FCR_CONSTS_SVH

// Register indices
`define FCR_REG_KNEE 7'h1A
`define FCR_REG_OVR 7'h1C
`define FCR_REG_UVR 7'h1E
`define FCR_REG_OSR 7'h20
`define FCR_REG_SPR 7'h22
`define FCR_REG_UVT 7'h24
`define FCR_REG_WDP 7'h26
`define FCR_REG_CVR 7'h28
`define FCR_REG_CVT 7'h2A
`define FCR_REG_IMASK 7'h2C
`define FCR_REG_OTH 7'h2E

// Reset values
`define FCR_KNEE_RST 8'hF0
`define FCR_OVR_RST 8'h02
`define FCR_UVR_RST 8'h00
`define FCR_OSR_RST 8'h02
`define FCR_SPR_RST 8'h00
`define FCR_UVT_RST 8'h03
`define FCR_WDP_RST 8'h01
`define FCR_CVR_RST 8'h00
`define FCR_CVT_RST 8'h00
`define FCR_IMASK_RST 8'h00
`define FCR_OTH_RST 8'h00

// Knee voltage range in 100 mV steps
`define FCR_KNEE_MIN 8'h35
`define FCR_KNEE_MAX 8'hF0

// Field positions
`define FCR_KNEE_HI_BIT 8
`define FCR_PAR_HI_BIT 15
`define FCR_PAR_LO_BIT 7

// Timing
`define FCR_CLK_MHZ 100
`define FCR_WDT_BASE_MS 500
`define FCR_TIMER_BASE_MS 7'h08

`endif

/* File: core/fcr_pkg.sv */
// Purpose: Types shared by the fault configuration register bank
// Assumes: Constants live in fcr_consts.svh
// Notes: Response codes are normalised; each register's own coding is decoded in the bank
package fcr_pkg;

  typedef enum logic [1:0] {
    FCR_RESP_NONE  = 2'b00,
    FCR_RESP_LATCH = 2'b01,
    FCR_RESP_AUTO  = 2'b10
  } fcr_resp_t;

  // Decoded settings handed to the converter logic
  typedef struct packed {
    logic [7:0] knee_volt;
    fcr_resp_t ov_resp;
    fcr_resp_t uv_resp;
    fcr_resp_t short_resp;
    fcr_resp_t sense_resp;
    logic [6:0] sense_freq_khz;
    logic [6:0] uv_timer_ms;
    fcr_resp_t cv_resp;
    logic [6:0] cv_timer_ms;
    logic wdt_enable;
    logic [6:0] irq_enable;
    logic otp_hys_60c;
  } fcr_cfg_t;

  typedef enum logic [2:0] {
    FCR_S_IDLE = 3'b000,
    FCR_S_DEV  = 3'b001,
    FCR_S_REG  = 3'b010,
    FCR_S_WR   = 3'b011,
    FCR_S_RD   = 3'b100,
    FCR_S_ACK  = 3'b101,
    FCR_S_MACK = 3'b110
  } fcr_i2c_st_t;

  typedef struct packed {
    logic scl_s1;
    logic scl_s2;
    logic scl_p;
    logic sda_s1;
    logic sda_s2;
    logic sda_p;
    fcr_i2c_st_t st;
    fcr_i2c_st_t after;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [6:0] reg_idx;
    logic byte_idx;
    logic sda_o;
    logic sda_oe_n;
    logic wr_stb;
    logic comm;
  } fcr_i2c_t;

  typedef struct packed {
    logic [7:0] knee_val;
    logic [1:0] knee_par;
    logic [7:0] knee_lo;
    logic [7:0] ovr;
    logic [7:0] uvr;
    logic [7:0] osr;
    logic [7:0] spr;
    logic [7:0] uvt;
    logic [7:0] wdp;
    logic [7:0] cvr;
    logic [7:0] cvt;
    logic [7:0] imask;
    logic [7:0] oth;
    logic irq;
    logic [31:0] wdt_cnt;
    logic wdt_exp;
    fcr_cfg_t cfg;
  } fcr_regs_t;

endpackage

/* File: core/fcr_i2c_slave.sv */
// Purpose: Serial register port: start/stop, device address, register index, data bytes
// Assumes: Pins are asynchronous and pass two flip-flops; sda is open drain
// Notes: Register index byte accepted plain or with bit 7 set when the byte has odd parity
`include "fcr_consts.svh"
module fcr_i2c_slave #(
  parameter logic [6:0] DEV_ADDR = 7'h18
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic [7:0] rd_byte,
  output logic sda_out,
  output logic sda_oe_n,
  output logic wr_stb,
  output logic [7:0] wr_data,
  output logic [6:0] reg_idx,
  output logic byte_idx,
  output logic comm
);
  import fcr_pkg::*;

  fcr_i2c_t q_ff, nxt_q;
  logic rise, fall, start, stop;

  // Bus events from the synchronised pins
  assign rise = q_ff.scl_s2 & ~q_ff.scl_p;
  assign fall = ~q_ff.scl_s2 & q_ff.scl_p;
  assign start = q_ff.scl_s2 & q_ff.scl_p & ~q_ff.sda_s2 & q_ff.sda_p;
  assign stop = q_ff.scl_s2 & q_ff.scl_p & q_ff.sda_s2 & ~q_ff.sda_p;

  // Byte engine
  always_comb begin
    nxt_q = q_ff;
    nxt_q.scl_s1 = scl_in;
    nxt_q.scl_s2 = q_ff.scl_s1;
    nxt_q.scl_p = q_ff.scl_s2;
    nxt_q.sda_s1 = sda_in;
    nxt_q.sda_s2 = q_ff.sda_s1;
    nxt_q.sda_p = q_ff.sda_s2;
    nxt_q.wr_stb = 1'b0;
    nxt_q.comm = 1'b0;
    // After the first data strobe, later bytes of the frame go to the high byte slot
    if (q_ff.wr_stb) begin
      nxt_q.byte_idx = 1'b1;
    end
    if (stop) begin
      nxt_q.st = FCR_S_IDLE;
      nxt_q.sda_oe_n = 1'b1;
    end else if (start) begin
      nxt_q.st = FCR_S_DEV;
      nxt_q.cnt = 4'h0;
      nxt_q.sda_oe_n = 1'b1;
    end else if (rise) begin
      unique case (q_ff.st)
        FCR_S_DEV, FCR_S_REG, FCR_S_WR: begin
          nxt_q.sh = {q_ff.sh[6:0], q_ff.sda_s2};
          nxt_q.cnt = q_ff.cnt + 4'h1;
        end
        FCR_S_MACK: begin
          nxt_q.after = q_ff.sda_s2 ? FCR_S_IDLE : FCR_S_RD;
          // Switch slot at the ack so the high byte is ready by the falling edge
          if (!q_ff.sda_s2) begin
            nxt_q.byte_idx = 1'b1;
          end
        end
        FCR_S_IDLE, FCR_S_RD, FCR_S_ACK: ;
      endcase
    end else if (fall) begin
      unique case (q_ff.st)
        FCR_S_DEV: if (q_ff.cnt == 4'h8) begin
          if (q_ff.sh[7:1] == DEV_ADDR) begin
            nxt_q.st = FCR_S_ACK;
            nxt_q.sda_oe_n = 1'b0;
            nxt_q.after = q_ff.sh[0] ? FCR_S_RD : FCR_S_REG;
            nxt_q.comm = 1'b1;
          end else begin
            nxt_q.st = FCR_S_IDLE;
          end
        end
        FCR_S_REG: if (q_ff.cnt == 4'h8) begin
          if (~q_ff.sh[7] | (^q_ff.sh)) begin
            nxt_q.st = FCR_S_ACK;
            nxt_q.sda_oe_n = 1'b0;
            nxt_q.after = FCR_S_WR;
            nxt_q.reg_idx = q_ff.sh[6:0];
            nxt_q.byte_idx = 1'b0;
          end else begin
            nxt_q.st = FCR_S_IDLE;
          end
        end
        FCR_S_WR: if (q_ff.cnt == 4'h8) begin
          nxt_q.st = FCR_S_ACK;
          nxt_q.sda_oe_n = 1'b0;
          nxt_q.after = FCR_S_WR;
          nxt_q.wr_stb = 1'b1;
        end
        FCR_S_ACK: begin
          nxt_q.cnt = 4'h0;
          nxt_q.sda_oe_n = 1'b1;
          nxt_q.st = q_ff.after;
          if (q_ff.after == FCR_S_RD) begin
            nxt_q.sh = {rd_byte[6:0], 1'b0};
            nxt_q.sda_oe_n = rd_byte[7];
            nxt_q.cnt = 4'h1;
          end
        end
        FCR_S_RD: if (q_ff.cnt == 4'h8) begin
          nxt_q.st = FCR_S_MACK;
          nxt_q.sda_oe_n = 1'b1;
        end else begin
          nxt_q.sda_oe_n = q_ff.sh[7];
          nxt_q.sh = {q_ff.sh[6:0], 1'b0};
          nxt_q.cnt = q_ff.cnt + 4'h1;
        end
        FCR_S_MACK: if (q_ff.after == FCR_S_RD) begin
          // Next byte's first bit goes out right at this falling edge
          nxt_q.st = FCR_S_RD;
          nxt_q.sh = {rd_byte[6:0], 1'b0};
          nxt_q.sda_oe_n = rd_byte[7];
          nxt_q.cnt = 4'h1;
        end else begin
          nxt_q.st = FCR_S_IDLE;
        end
        FCR_S_IDLE: ;
      endcase
    end
  end

  // State register
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      q_ff <= '{scl_s1: 1'b1, scl_s2: 1'b1, scl_p: 1'b1, sda_s1: 1'b1, sda_s2: 1'b1, sda_p: 1'b1,
                st: FCR_S_IDLE, after: FCR_S_IDLE, cnt: 4'h0, sh: 8'h00, reg_idx: 7'h00,
                byte_idx: 1'b0, sda_o: 1'b0, sda_oe_n: 1'b1, wr_stb: 1'b0, comm: 1'b0};
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign sda_out = q_ff.sda_o;
  assign sda_oe_n = q_ff.sda_oe_n;
  assign wr_stb = q_ff.wr_stb;
  assign wr_data = q_ff.sh;
  assign reg_idx = q_ff.reg_idx;
  assign byte_idx = q_ff.byte_idx;
  assign comm = q_ff.comm;
endmodule

/* File: core/fcr_fault_config_regs.sv */
// Purpose: Writable fault configuration bank of a power converter controller, reached over I2C
// Assumes: 100 MHz clk_sys; fault_events come from logic on clk_sys
// Notes: Decoded settings leave on cfg, registered together with the raw registers
//
// What this block does
// - Knee voltage word: 53..240 at 100 mV, top bit in bit 8, parity bits 15 and 7.
// - Overvoltage and sense pin short: 00 none, 01 latch off, 10 auto restart.
// - Undervoltage response: 00 auto restart, 01 latch off, 10 none; reset gives auto restart.
// - Output short response: 00 none, 10 auto restart; never latch off.
// - Constant voltage fault response: 00 none, 01 auto restart, 10 latch off.
// - Sense pin detection threshold: 00 50 kHz, 01 30, 10 40, 11 60 kHz.
// - Undervoltage and constant voltage timers: 8, 16, 32, 64 ms.
// - Watchdog: 00 off, else 0.5, 1, 2 s; master must talk within the period.
// - Interrupt mask bits 0..6 gate events; one pulse sent, then mask clears itself.
`include "fcr_consts.svh"
module fcr_fault_config_regs #(
  parameter logic [6:0] DEV_ADDR = 7'h18,
  parameter logic [31:0] WDT_BASE_CYCLES = 32'(`FCR_WDT_BASE_MS * 1000 * `FCR_CLK_MHZ)
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic [6:0] fault_events,
  output fcr_pkg::fcr_cfg_t cfg,
  output logic irq_pulse,
  output logic wdt_expired
);
  import fcr_pkg::*;

  fcr_regs_t r_ff, nxt_r;
  logic wr_stb, byte_idx, comm;
  logic [7:0] wr_data, rd_byte;
  logic [6:0] reg_idx;
  logic [7:0] knee_new;
  logic imask_wr;

  // Standard three-way coding
  function automatic fcr_resp_t dec_std(input logic [1:0] c);
    unique case (c)
      2'b01: dec_std = FCR_RESP_LATCH;
      2'b10: dec_std = FCR_RESP_AUTO;
      default: dec_std = FCR_RESP_NONE;
    endcase
  endfunction

  function automatic logic [6:0] dec_ms(input logic [1:0] c);
    dec_ms = `FCR_TIMER_BASE_MS << c;
  endfunction

  function automatic logic [31:0] wdt_limit(input logic [1:0] c);
    wdt_limit = WDT_BASE_CYCLES << (c - 2'b01);
  endfunction

  fcr_i2c_slave #(.DEV_ADDR(DEV_ADDR)) u_port (
    .clk_sys(clk_sys),
    .reset(reset),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .rd_byte(rd_byte),
    .sda_out(sda_out),
    .sda_oe_n(sda_oe_n),
    .wr_stb(wr_stb),
    .wr_data(wr_data),
    .reg_idx(reg_idx),
    .byte_idx(byte_idx),
    .comm(comm)
  );

  // Read-back byte for the addressed register
  always_comb begin
    rd_byte = 8'h00;
    unique case (reg_idx)
      `FCR_REG_KNEE: rd_byte = byte_idx ? {r_ff.knee_par[1], 6'h00, r_ff.knee_val[7]} :
                                          {r_ff.knee_par[0], r_ff.knee_val[6:0]};
      `FCR_REG_OVR: rd_byte = r_ff.ovr;
      `FCR_REG_UVR: rd_byte = r_ff.uvr;
      `FCR_REG_OSR: rd_byte = r_ff.osr;
      `FCR_REG_SPR: rd_byte = r_ff.spr;
      `FCR_REG_UVT: rd_byte = r_ff.uvt;
      `FCR_REG_WDP: rd_byte = r_ff.wdp;
      `FCR_REG_CVR: rd_byte = r_ff.cvr;
      `FCR_REG_CVT: rd_byte = r_ff.cvt;
      `FCR_REG_IMASK: rd_byte = r_ff.imask;
      `FCR_REG_OTH: rd_byte = r_ff.oth;
      default: rd_byte = 8'h00;
    endcase
  end

  assign knee_new = {wr_data[0], r_ff.knee_lo[6:0]};
  assign imask_wr = wr_stb && !byte_idx && reg_idx == `FCR_REG_IMASK;

  // Register writes, interrupt, watchdog and decode
  always_comb begin
    nxt_r = r_ff;
    nxt_r.irq = 1'b0;
    if (wr_stb && !byte_idx) begin
      unique case (reg_idx)
        `FCR_REG_KNEE: nxt_r.knee_lo = wr_data;
        `FCR_REG_OVR: nxt_r.ovr = wr_data;
        `FCR_REG_UVR: nxt_r.uvr = wr_data;
        `FCR_REG_OSR: nxt_r.osr = wr_data;
        `FCR_REG_SPR: nxt_r.spr = wr_data;
        `FCR_REG_UVT: nxt_r.uvt = wr_data;
        `FCR_REG_WDP: nxt_r.wdp = wr_data;
        `FCR_REG_CVR: nxt_r.cvr = wr_data;
        `FCR_REG_CVT: nxt_r.cvt = wr_data;
        `FCR_REG_IMASK: nxt_r.imask = wr_data;
        `FCR_REG_OTH: nxt_r.oth = wr_data;
        default: ;
      endcase
    end
    // Knee value commits on the high byte, only inside its range
    if (wr_stb && byte_idx && reg_idx == `FCR_REG_KNEE &&
        knee_new >= `FCR_KNEE_MIN && knee_new <= `FCR_KNEE_MAX) begin
      nxt_r.knee_val = knee_new;
      nxt_r.knee_par = {wr_data[7], r_ff.knee_lo[7]};
    end
    // One pulse per enable; a mask write in the same cycle wins
    if (!imask_wr && r_ff.imask[6:0] != 7'h00 && (fault_events & r_ff.imask[6:0]) != 7'h00) begin
      nxt_r.irq = 1'b1;
      nxt_r.imask = 8'h00;
    end
    // Watchdog restarts on every addressed transfer
    if (comm || r_ff.wdp[1:0] == 2'b00) begin
      nxt_r.wdt_cnt = 32'h0;
      nxt_r.wdt_exp = 1'b0;
    end else if (r_ff.wdt_cnt >= wdt_limit(r_ff.wdp[1:0]) - 32'h1) begin
      nxt_r.wdt_exp = 1'b1;
    end else begin
      nxt_r.wdt_cnt = r_ff.wdt_cnt + 32'h1;
    end
    // Decoded settings follow the registers in the same cycle
    nxt_r.cfg.knee_volt = nxt_r.knee_val;
    nxt_r.cfg.ov_resp = dec_std(nxt_r.ovr[1:0]);
    nxt_r.cfg.sense_resp = dec_std(nxt_r.spr[1:0]);
    unique case (nxt_r.uvr[1:0])
      2'b00: nxt_r.cfg.uv_resp = FCR_RESP_AUTO;
      2'b01: nxt_r.cfg.uv_resp = FCR_RESP_LATCH;
      default: nxt_r.cfg.uv_resp = FCR_RESP_NONE;
    endcase
    nxt_r.cfg.short_resp = (nxt_r.osr[1:0] == 2'b10) ? FCR_RESP_AUTO : FCR_RESP_NONE;
    unique case (nxt_r.cvr[1:0])
      2'b01: nxt_r.cfg.cv_resp = FCR_RESP_AUTO;
      2'b10: nxt_r.cfg.cv_resp = FCR_RESP_LATCH;
      default: nxt_r.cfg.cv_resp = FCR_RESP_NONE;
    endcase
    unique case (nxt_r.spr[3:2])
      2'b00: nxt_r.cfg.sense_freq_khz = 7'd50;
      2'b01: nxt_r.cfg.sense_freq_khz = 7'd30;
      2'b10: nxt_r.cfg.sense_freq_khz = 7'd40;
      2'b11: nxt_r.cfg.sense_freq_khz = 7'd60;
    endcase
    nxt_r.cfg.uv_timer_ms = dec_ms(nxt_r.uvt[1:0]);
    nxt_r.cfg.cv_timer_ms = dec_ms(nxt_r.cvt[1:0]);
    nxt_r.cfg.wdt_enable = nxt_r.wdp[1:0] != 2'b00;
    nxt_r.cfg.irq_enable = nxt_r.imask[6:0];
    nxt_r.cfg.otp_hys_60c = nxt_r.oth[0];
  end

  // State register
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      r_ff <= '{knee_val: `FCR_KNEE_RST, knee_par: 2'b00, knee_lo: 8'h00, ovr: `FCR_OVR_RST,
                uvr: `FCR_UVR_RST, osr: `FCR_OSR_RST, spr: `FCR_SPR_RST, uvt: `FCR_UVT_RST,
                wdp: `FCR_WDP_RST, cvr: `FCR_CVR_RST, cvt: `FCR_CVT_RST, imask: `FCR_IMASK_RST,
                oth: `FCR_OTH_RST, irq: 1'b0, wdt_cnt: 32'h0, wdt_exp: 1'b0,
                cfg: '{knee_volt: `FCR_KNEE_RST, ov_resp: FCR_RESP_AUTO, uv_resp: FCR_RESP_AUTO,
                       short_resp: FCR_RESP_AUTO, sense_resp: FCR_RESP_NONE, sense_freq_khz: 7'd50,
                       uv_timer_ms: 7'd64, cv_resp: FCR_RESP_NONE, cv_timer_ms: 7'd8,
                       wdt_enable: 1'b1, irq_enable: 7'h00, otp_hys_60c: 1'b0}};
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign cfg = r_ff.cfg;
  assign irq_pulse = r_ff.irq;
  assign wdt_expired = r_ff.wdt_exp;

  // Checks
  sequence s_wr(logic [6:0] idx, logic [1:0] code);
    wr_stb && !byte_idx && reg_idx == idx && wr_data[1:0] == code;
  endsequence

  chk_knee_in_range: assert property (@(posedge clk_sys) disable iff (reset)
    cfg.knee_volt >= 8'd53 && cfg.knee_volt <= 8'd240) else $error("knee voltage out of range");
  chk_ov_latch_code: assert property (@(posedge clk_sys) disable iff (reset)
    s_wr(`FCR_REG_OVR, 2'b01) |=> cfg.ov_resp == FCR_RESP_LATCH) else $error("overvoltage 01 not latch off");
  chk_uv_auto_code: assert property (@(posedge clk_sys) disable iff (reset)
    s_wr(`FCR_REG_UVR, 2'b00) |=> cfg.uv_resp == FCR_RESP_AUTO) else $error("undervoltage 00 not auto restart");
  chk_short_no_latch: assert property (@(posedge clk_sys) disable iff (reset)
    cfg.short_resp != FCR_RESP_LATCH) else $error("output short shows latch off");
  chk_cv_latch_code: assert property (@(posedge clk_sys) disable iff (reset)
    s_wr(`FCR_REG_CVR, 2'b10) |=> cfg.cv_resp == FCR_RESP_LATCH) else $error("cv fault 10 not latch off");
  chk_sense_freq_30: assert property (@(posedge clk_sys) disable iff (reset)
    wr_stb && !byte_idx && reg_idx == `FCR_REG_SPR && wr_data[3:2] == 2'b01 |=> cfg.sense_freq_khz == 7'd30)
    else $error("sense threshold 01 not 30 kHz");
  chk_uv_timer_64: assert property (@(posedge clk_sys) disable iff (reset)
    s_wr(`FCR_REG_UVT, 2'b11) |=> cfg.uv_timer_ms == 7'd64) else $error("timer 11 not 64 ms");
  chk_wdt_comm_clear: assert property (@(posedge clk_sys) disable iff (reset)
    comm || !cfg.wdt_enable |=> !wdt_expired) else $error("watchdog flag after traffic or while off");
  chk_irq_single_pulse: assert property (@(posedge clk_sys) disable iff (reset)
    irq_pulse |-> $past((fault_events & r_ff.imask[6:0]) != 7'h00) ##1 !irq_pulse)
    else $error("interrupt pulse without cause or repeated");
endmodule

/* File: dv/fcr_i2c_mst.sv */
// Purpose: Serial bus master model that reaches the register port
// Assumes: Phases of HALF clk_sys cycles; changes made at falling clk edges
// Notes: sda released goes to the pull-up; scl stands high between frames
module fcr_i2c_mst #(
  parameter int HALF = 5
) (
  input wire logic clk_sys,
  input wire logic sda_line,
  output logic scl_drv,
  output logic sda_drv
);
  timeunit 1ns;
  timeprecision 1ps;
  // Both lines released at start
  initial begin
    scl_drv = 1'b1;
    sda_drv = 1'b1;
  end
  // Wait n falling clock edges
  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  // Start or repeated start: sda falls while scl is high
  task automatic start_cond();
    tick(1);
    sda_drv = 1'b1;
    tick(HALF);
    scl_drv = 1'b1;
    tick(HALF);
    sda_drv = 1'b0;
    tick(HALF);
    scl_drv = 1'b0;
  endtask
  // Stop: sda rises while scl is high
  task automatic stop_cond();
    tick(1);
    sda_drv = 1'b0;
    tick(HALF);
    scl_drv = 1'b1;
    tick(HALF);
    sda_drv = 1'b1;
    tick(HALF);
  endtask
  // Data moves one cycle after scl falls, so it never looks like a start
  task automatic put_bit(input logic b);
    tick(1);
    sda_drv = b;
    tick(HALF);
    scl_drv = 1'b1;
    tick(HALF);
    scl_drv = 1'b0;
  endtask
  // Release sda and sample it in the middle of the high phase
  task automatic get_bit(output logic b);
    tick(1);
    sda_drv = 1'b1;
    tick(HALF);
    scl_drv = 1'b1;
    tick(2);
    b = sda_line;
    tick(HALF - 2);
    scl_drv = 1'b0;
  endtask
  // Byte out, msb first, then the slave's acknowledge
  task automatic put_byte(input logic [7:0] d, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) put_bit(d[i]);
    get_bit(a);
    ack = ~a;
  endtask
  // Byte in, then our acknowledge or a nack on the last byte
  task automatic get_byte(output logic [7:0] d, input logic last);
    for (int i = 7; i >= 0; i--) get_bit(d[i]);
    put_bit(last);
  endtask
endmodule

/* File: dv/testbench.sv */
// Purpose: Self-checking bench for the fault configuration register bank
// Assumes: Serial master model on the bus; watchdog base span shortened to 2000 cycles
// Notes: Expected values come from the register coding tables below
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import fcr_pkg::*;
  localparam logic [6:0] DEV = 7'h18;
  logic clk_sys, reset, scl_drv, sda_drv, sda_w, sda_out, sda_oe_n, irq_pulse, wdt_expired;
  logic [6:0] fault_events;
  logic [1:0] ak;
  logic [15:0] rd, w;
  logic [3:0] seen;
  fcr_cfg_t cfg;
  int miscompares, compares;
  // Decoded response per code 00..11: none 0, latch 1, auto 2
  localparam logic [1:0] OVX [4] = '{2'h0, 2'h1, 2'h2, 2'h0};
  localparam logic [1:0] UVX [4] = '{2'h2, 2'h1, 2'h0, 2'h0};
  localparam logic [1:0] OSX [4] = '{2'h0, 2'h0, 2'h2, 2'h0};
  localparam logic [1:0] CVX [4] = '{2'h0, 2'h2, 2'h1, 2'h0};
  localparam logic [6:0] FRQ [4] = '{7'h32, 7'h1E, 7'h28, 7'h3C};
  localparam logic [6:0] TMR [4] = '{7'h08, 7'h10, 7'h20, 7'h40};
  localparam logic [7:0] RIDX [10] = '{8'h1C, 8'h1E, 8'h20, 8'h22, 8'h24, 8'h26, 8'h28, 8'h2A, 8'h2C, 8'h2E};
  localparam logic [7:0] RRST [10] = '{8'h02, 8'h00, 8'h02, 8'h00, 8'h03, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0] KV [5] = '{8'h35, 8'h34, 8'hC8, 8'hF1, 8'hF0};
  localparam logic [7:0] KE [5] = '{8'h35, 8'h35, 8'hC8, 8'hC8, 8'hF0};
  // 100 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // Open-drain data wire with pull-up
  assign sda_w = sda_oe_n ? sda_drv : (sda_drv & sda_out);
  fcr_fault_config_regs #(.DEV_ADDR(DEV), .WDT_BASE_CYCLES(32'h0000_07D0)) dut_u (
    .clk_sys(clk_sys), .reset(reset), .scl_in(scl_drv), .sda_in(sda_w), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .fault_events(fault_events), .cfg(cfg), .irq_pulse(irq_pulse),
    .wdt_expired(wdt_expired));
  fcr_i2c_mst mst_u (.clk_sys(clk_sys), .sda_line(sda_w), .scl_drv(scl_drv), .sda_drv(sda_drv));
  // Index with bit 7 set only where bits 6..0 have even parity, so that the byte has odd parity
  function automatic logic [7:0] pi(input logic [7:0] i);
    return {~^i[6:0], i[6:0]};
  endfunction
  // Knee word with odd parity on each byte
  function automatic logic [15:0] kw(input logic [7:0] v);
    return {~v[7], 6'h00, v[7], ~^v[6:0], v[6:0]};
  endfunction
  // Compare and count
  task automatic check(input string what, input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Write frame; ak holds the address and index acknowledges
  task automatic wf(input logic [6:0] dev, input logic [7:0] idx, input logic [7:0] dq[$]);
    logic a;
    mst_u.start_cond();
    mst_u.put_byte({dev, 1'b0}, ak[1]);
    mst_u.put_byte(idx, ak[0]);
    foreach (dq[i]) mst_u.put_byte(dq[i], a);
    mst_u.stop_cond();
  endtask
  // One-byte register write
  task automatic wb(input logic [7:0] idx, input logic [7:0] d);
    wf(DEV, idx, '{d});
  endtask
  // Read n bytes, low byte first, into rd
  task automatic rf(input logic [7:0] idx, input int n);
    logic a;
    logic [7:0] b;
    rd = 16'h0000;
    mst_u.start_cond();
    mst_u.put_byte({DEV, 1'b0}, a);
    mst_u.put_byte(idx, a);
    mst_u.start_cond();
    mst_u.put_byte({DEV, 1'b1}, a);
    for (int i = 0; i < n; i++) begin
      mst_u.get_byte(b, i == n - 1);
      rd[8*i +: 8] = b;
    end
    mst_u.stop_cond();
  endtask
  // Hold events one cycle, record the pulse over four cycles
  task automatic fire(input logic [6:0] ev);
    fault_events = ev;
    for (int i = 0; i < 4; i++) begin
      @(negedge clk_sys);
      fault_events = 7'h00;
      seen[i] = irq_pulse;
    end
  endtask
  // Wait a span with no traffic, then look at the expiry flag
  task automatic wdt_at(input int n, input logic e);
    repeat (n) @(negedge clk_sys);
    check("wdt_expired", 16'(wdt_expired), 16'(e));
  endtask
  // Counts and verdict
  task automatic end_sim();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    reset = 1'b1;
    fault_events = 7'h00;
    repeat (12) @(posedge clk_sys);
    @(negedge clk_sys);
    reset = 1'b0;
    repeat (2) @(negedge clk_sys);
    // Decoded settings and pins out of reset
    check("rst_knee", 16'(cfg.knee_volt), 16'h00F0);
    check("rst_resp", 16'({cfg.ov_resp, cfg.uv_resp, cfg.short_resp, cfg.sense_resp, cfg.cv_resp}), 16'h02A0);
    check("rst_time", 16'({cfg.sense_freq_khz, cfg.uv_timer_ms}), 16'({7'h32, 7'h40}));
    check("rst_misc", {cfg.cv_timer_ms, cfg.wdt_enable, cfg.irq_enable, cfg.otp_hys_60c}, 16'h1100);
    check("rst_pins", {12'h000, sda_out, irq_pulse, wdt_expired, sda_oe_n}, 16'h0001);
    // Raw reset values read back
    rf(8'h1A, 2);
    check("knee_raw", rd, 16'h0170);
    foreach (RIDX[i]) begin
      rf(RIDX[i], 1);
      check("reg_reset", rd, 16'(RRST[i]));
    end
    // Unmapped index: write dropped, reads zero
    wb(8'h30, 8'h55);
    rf(8'h30, 1);
    check("unmapped", rd, 16'h0000);
    // Every code of each response, threshold and timer field
    for (int c = 0; c < 4; c++) begin
      wb(8'h1C, 8'(c));
      wb(pi(8'h1E), 8'(c));
      wb(8'h20, 8'(c));
      wb(8'h22, 8'(5 * c));
      wb(pi(8'h28), 8'(c));
      wb(8'h24, 8'(c));
      wb(pi(8'h2A), 8'(c));
      wb(8'h26, 8'(c));
      wb(8'h2E, 8'(c));
      check("resp", 16'({cfg.ov_resp, cfg.uv_resp, cfg.short_resp, cfg.sense_resp, cfg.cv_resp}),
        16'({OVX[c], UVX[c], OSX[c], OVX[c], CVX[c]}));
      check("freq_uvt", 16'({cfg.sense_freq_khz, cfg.uv_timer_ms}), 16'({FRQ[c], TMR[c]}));
      check("cvt_wdt_hys", 16'({cfg.cv_timer_ms, cfg.wdt_enable, cfg.otp_hys_60c}),
        16'({TMR[c], c != 0, c[0]}));
      rf(8'h22, 1);
      check("sense_raw", rd, 16'(5 * c));
    end
    // Even-parity index and foreign address are both ignored
    wf(DEV, 8'h9C, '{8'h01});
    check("bad_par_ack", 16'(ak), 16'h0002);
    wf(DEV + 7'h01, 8'h1C, '{8'h01});
    check("foreign_ack", 16'(ak), 16'h0000);
    check("ov_kept", 16'(cfg.ov_resp), 16'h0000);
    // Knee word: range ends and values just outside
    foreach (KV[i]) begin
      w = kw(KV[i]);
      wf(DEV, 8'h1A, '{w[7:0], w[15:8]});
      check("knee", 16'(cfg.knee_volt), 16'(KE[i]));
      if (KV[i] == KE[i]) begin
        rf(8'h1A, 2);
        check("knee_raw", rd, kw(KE[i]));
      end
    end
    // Each interrupt source: others ignored, own one pulses once and disarms
    for (int j = 0; j < 7; j++) begin
      wb(8'h2C, 8'(1 << j));
      fire(~7'(1 << j));
      check("irq_other", {seen, 5'h00, cfg.irq_enable}, {4'h0, 5'h00, 7'(1 << j)});
      fire(7'(1 << j));
      check("irq_own", {seen, 5'h00, cfg.irq_enable}, 16'h1000);
    end
    rf(8'h2C, 1);
    check("mask_clear", rd, 16'h0000);
    // Watchdog at one and four base spans, then disabled
    wb(8'h26, 8'h01);
    wdt_at(0, 1'b0);
    wdt_at(1000, 1'b0);
    wdt_at(1500, 1'b1);
    wb(8'h26, 8'h03);
    wdt_at(0, 1'b0);
    wdt_at(6000, 1'b0);
    wdt_at(3000, 1'b1);
    wb(8'h26, 8'h00);
    wdt_at(9000, 1'b0);
    end_sim();
  end
  // Hang guard at 90000 cycles, beyond the roughly 50000 cycles the tests need
  initial begin
    #900_000;
    miscompares++;
    $display("MISMATCH run_time expected done seen hang");
    end_sim();
  end
endmodule
